//--- design/sct_pkg.sv
// Package for the six-channel compare/PWM timer block.
// Assumes a classic Wishbone slave port with 32-bit data and byte addresses.
package sct_pkg;

  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int CNT_W = 16;
  localparam int CTL_W = 8;
  localparam int NCH   = 6;
  localparam int NPAIR = 3;

  // Register byte offsets
  localparam logic [7:0] OFF_STAT = 8'h00;
  localparam logic [7:0] OFF_MOD  = 8'h04;
  localparam logic [7:0] OFF_CNT  = 8'h08;
  localparam logic [7:0] OFF_CTL0 = 8'h20;
  localparam logic [7:0] OFF_CMP0 = 8'h40;
  localparam logic [7:0] OFF_STEP = 8'h04;

  // Status/control field positions
  localparam int STAT_STOP = 0;
  localparam int STAT_TRST = 1;
  localparam int STAT_OVF  = 7;

  // Channel control field positions
  localparam int CTL_TOV    = 0;
  localparam int CTL_ELS_LO = 1;
  localparam int CTL_ELS_HI = 2;
  localparam int CTL_MSA    = 3;
  localparam int CTL_MSB    = 4;
  localparam int CTL_MAX    = 5;
  localparam int CTL_FLAG   = 7;

  // Reset value and counter step
  localparam logic [15:0] MOD_RST  = 16'hFFFF;
  localparam logic [15:0] CNT_ONE  = 16'h0001;

  typedef enum logic [1:0] {
    ELS_OFF    = 2'b00,
    ELS_TOGGLE = 2'b01,
    ELS_CLEAR  = 2'b10,
    ELS_SET    = 2'b11
  } sct_els_t;

  typedef struct packed {
    logic [15:0]          cnt;
    logic [15:0]          modv;
    logic                 stop;
    logic                 ovf_flag;
    logic [5:0][7:0]      ctl;
    logic [5:0][15:0]     cmp;
    logic [5:0]           pin;
    logic [2:0]           sel;
    logic [2:0]           last;
    logic                 ack;
    logic [31:0]          rdat;
  } sct_state_t;

endpackage

//--- design/sct_timer.sv
// Six-channel 16-bit compare timer with toggle-on-overflow PWM and
// buffered (linked pair) compare for pairs 0/1, 2/3 and 4/5.
// Assumes a classic Wishbone master on sys_clk; the counter runs undivided.
//
// Summary of operation
// - Pair 2/3 link: channel 2 value first
// - Inactive-channel write hands over at overflow
// - Each overflow: last written channel governs
// - Linked: channel 3 ignored, pin released
// - Pair 4/5 link: channel 4 value first
// - Linked: channel 5 ignored, pin released
// - Toggle pin at overflow when enabled, unless a same-cycle compare match wins
// - Counter spans zero through modulo inclusive
// - Clear-on-compare duty equals compare over period count
// - Compare uses only the current value
// - Pair 0/1 link: channel 0 value first
// - Buffered PWM width changes next period
// - Linked: channel 1 ignored, pin released
// - Counter rolls to zero, sets overflow flag
// - Action field: 10 clears, 11 sets
// - Max bit without toggle gives full duty
// - Buffered select outranks unbuffered select

`timescale 1ns/1ps
`default_nettype none

module sct_timer (
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [sct_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [sct_pkg::SEL_W-1:0]   wb_sel_i,
  input  wire logic [sct_pkg::DAT_W-1:0]   wb_dat_i,
  output logic      [sct_pkg::DAT_W-1:0]   wb_dat_o,
  output logic                             wb_ack_o,
  output logic      [sct_pkg::NCH-1:0]     chan_pin_o,
  output logic      [sct_pkg::NCH-1:0]     chan_pin_oe
);
  import sct_pkg::*;

  sct_state_t       s;
  sct_state_t       n;
  logic             ovf;
  logic             wr;
  logic [DAT_W-1:0] rd;
  logic [NCH-1:0]   en;
  logic [NCH-1:0]   bufm;
  logic [NCH-1:0]   match;
  logic [5:0][15:0] act;
  logic [15:0]      cnt_nx;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] d,
                                          input logic [1:0]  be);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0] = d[7:0];
    if (be[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  function automatic logic [ADR_W-1:0] ctl_adr(input int i);
    return ADR_W'(OFF_CTL0 + OFF_STEP * i);
  endfunction

  function automatic logic [ADR_W-1:0] cmp_adr(input int i);
    return ADR_W'(OFF_CMP0 + OFF_STEP * i);
  endfunction

  // Overflow is the cycle the counter sits on the modulo value
  assign ovf = !s.stop && (s.cnt == s.modv);
  assign cnt_nx = ovf ? '0 : s.cnt + CNT_ONE;

  for (genvar g = 0; g < NCH; g++) begin : gch
    localparam int  PE  = g - (g % 2);
    localparam bit  ODD = (g % 2) == 1;
    // Only even channels own a link bit; it wins over the plain select
    assign bufm[g] = !ODD && s.ctl[PE][CTL_MSB];
    // Odd partner of a linked pair is dead and its pin goes back to the port
    assign en[g] = !(ODD && s.ctl[PE][CTL_MSB])
                   && (bufm[g] || s.ctl[g][CTL_MSA])
                   && (s.ctl[g][CTL_ELS_HI:CTL_ELS_LO] != ELS_OFF);
    assign act[g] = (bufm[g] && s.sel[PE/2]) ? s.cmp[PE+1] : s.cmp[g];
    // Live register value only; a value jumped over is simply missed
    // Match on the value being entered, so width equals the compare value
    assign match[g] = en[g] && !s.stop && (cnt_nx == act[g]);
    assign chan_pin_oe[g] = en[g];
    assign chan_pin_o[g] = s.pin[g];
  end

  always_comb begin
    n = s;
    rd = '0;
    wr = wb_cyc_i && wb_stb_i && wb_we_i && s.ack;

    // Counter: zero through modulo inclusive
    if (!s.stop) begin
      n.cnt = cnt_nx;
    end

    if (wr && wb_adr_i == OFF_STAT && wb_sel_i[0]) begin
      n.stop = wb_dat_i[STAT_STOP];
      if (wb_dat_i[STAT_TRST]) n.cnt = '0;
      if (wb_dat_i[STAT_OVF]) n.ovf_flag = 1'b0;
    end
    if (wr && wb_adr_i == OFF_MOD) begin
      n.modv = merge16(s.modv, wb_dat_i[15:0], wb_sel_i[1:0]);
    end

    for (int i = 0; i < NCH; i++) begin
      if (wr && wb_adr_i == ctl_adr(i) && wb_sel_i[0]) begin
        n.ctl[i][CTL_MAX:0] = wb_dat_i[CTL_MAX:0];
        if (wb_dat_i[CTL_FLAG]) n.ctl[i][CTL_FLAG] = 1'b0;
      end
      if (wr && wb_adr_i == cmp_adr(i) && (|wb_sel_i[1:0])) begin
        n.cmp[i] = merge16(s.cmp[i], wb_dat_i[15:0], wb_sel_i[1:0]);
        // Remember which half was written last
        n.last[i/2] = (i % 2) == 1;
      end
    end

    // Handover only at overflow, so a write never cuts a period short
    for (int p = 0; p < NPAIR; p++) begin
      if (!s.ctl[2*p][CTL_MSB]) begin
        n.sel[p] = 1'b0;
        n.last[p] = 1'b0;
      end else if (ovf) begin
        n.sel[p] = s.last[p];
      end
    end

    // Hardware set beats a same-cycle software clear
    if (ovf) n.ovf_flag = 1'b1;

    for (int i = 0; i < NCH; i++) begin
      if (en[i]) begin
        if (s.ctl[i][CTL_MAX] && !s.ctl[i][CTL_TOV]) begin
          n.pin[i] = 1'b1;
        end else begin
          if (ovf && s.ctl[i][CTL_TOV]) n.pin[i] = !s.pin[i];
          // Compare action applied after the toggle, so it wins at cnt==mod
          case (sct_els_t'(s.ctl[i][CTL_ELS_HI:CTL_ELS_LO]))
            ELS_TOGGLE: if (match[i]) n.pin[i] = !n.pin[i];
            ELS_CLEAR:  if (match[i]) n.pin[i] = 1'b0;
            ELS_SET:    if (match[i]) n.pin[i] = 1'b1;
            default:    n.pin[i] = n.pin[i];
          endcase
        end
      end
      if (match[i]) n.ctl[i][CTL_FLAG] = 1'b1;
    end

    // Bus: one wait state, ack lasts one cycle
    if (wb_adr_i == OFF_STAT) begin
      rd[STAT_STOP] = s.stop;
      rd[STAT_OVF] = s.ovf_flag;
    end
    if (wb_adr_i == OFF_MOD) rd[15:0] = s.modv;
    if (wb_adr_i == OFF_CNT) rd[15:0] = s.cnt;
    for (int i = 0; i < NCH; i++) begin
      if (wb_adr_i == ctl_adr(i)) rd[CTL_W-1:0] = s.ctl[i];
      if (wb_adr_i == cmp_adr(i)) rd[15:0] = s.cmp[i];
    end
    n.ack = wb_cyc_i && wb_stb_i && !s.ack;
    if (n.ack) n.rdat = rd;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s <= '0;
      s.modv <= MOD_RST;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;

  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence ovf_s;
    ovf && !wr;
  endsequence

  sequence count_s;
    !s.stop && (s.cnt != s.modv) && !wr;
  endsequence

  sequence pair0_still_s;
    s.ctl[0][CTL_MSB] && !ovf && !wr;
  endsequence

  sequence pair1_still_s;
    s.ctl[2][CTL_MSB] && !ovf && !wr;
  endsequence

  sequence pair2_still_s;
    s.ctl[4][CTL_MSB] && !ovf && !wr;
  endsequence

  counter_wrap_a: assert property (
    ovf_s |=> (s.cnt == 16'h0000) && s.ovf_flag)
    else $error("counter did not wrap or flag not set");

  count_step_a: assert property (
    count_s |=> s.cnt == $past(s.cnt) + 16'h0001)
    else $error("counter did not step by one");

  buffer_hold_a: assert property (
    pair0_still_s |=> $stable(s.sel[0]))
    else $error("active channel changed between overflows");

  pair_handover_a: assert property (
    (ovf_s and s.ctl[2][CTL_MSB]) |=> s.sel[1] == $past(s.last[1]))
    else $error("handover did not pick last written channel");

  link_init0_a: assert property (
    !s.ctl[0][CTL_MSB] |=> !s.sel[0])
    else $error("pair 0 does not start on channel 0");

  link_init2_a: assert property (
    !s.ctl[2][CTL_MSB] |=> !s.sel[1])
    else $error("pair 2 does not start on channel 2");

  link_init4_a: assert property (
    !s.ctl[4][CTL_MSB] |=> !s.sel[2])
    else $error("pair 4 does not start on channel 4");

  pin3_release_a: assert property (
    s.ctl[2][CTL_MSB] |-> !chan_pin_oe[3])
    else $error("channel 3 pin still driven while linked");

  pin5_release_a: assert property (
    s.ctl[4][CTL_MSB] |-> !chan_pin_oe[5] && !match[5])
    else $error("channel 5 active while linked");

  pin1_release_a: assert property (
    s.ctl[0][CTL_MSB] |-> !chan_pin_oe[1] && !match[1])
    else $error("channel 1 active while linked");

  ovf_toggle_a: assert property (
    (ovf_s and en[0] && s.ctl[0][CTL_TOV] && !match[0])
      |=> chan_pin_o[0] != $past(chan_pin_o[0]))
    else $error("pin 0 did not toggle at overflow");

  clear_cmp_a: assert property (
    (match[2] && s.ctl[2][CTL_ELS_HI:CTL_ELS_LO] == ELS_CLEAR
      && !(s.ctl[2][CTL_MAX] && !s.ctl[2][CTL_TOV])) |=> !chan_pin_o[2])
    else $error("clear on compare failed");

  max_duty_a: assert property (
    (en[4] && s.ctl[4][CTL_MAX] && !s.ctl[4][CTL_TOV]) |=> chan_pin_o[4])
    else $error("max duty did not hold pin high");

  flag_set_a: assert property (
    match[3] |=> s.ctl[3][CTL_FLAG])
    else $error("channel flag not set on match");

  unbuf_cmp_a: assert property (
    (en[3] && !s.stop && cnt_nx == s.cmp[3]) |-> match[3])
    else $error("unbuffered compare missed live value");

  buf_priority_a: assert property (
    (s.ctl[0][CTL_MSB] && s.ctl[0][CTL_MSA] && s.sel[0] && en[0]
      && !s.stop && cnt_nx == s.cmp[1]) |-> match[0])
    else $error("link bit did not outrank plain select");

  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack lasted more than one cycle");

  ack_answer_a: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered next cycle");

  ovf_flag_hold_a: assert property (
    (s.ovf_flag && !wr) |=> s.ovf_flag)
    else $error("overflow flag lost without a clear");

  stop_hold_a: assert property (
    (s.stop && !wr) |=> $stable(s.cnt))
    else $error("counter moved while stopped");

  cnt_range_a: assert property (
    (s.cnt <= s.modv && !wr) |=> s.cnt <= s.modv)
    else $error("counter passed the modulo value");

  pin3_match_a: assert property (
    s.ctl[2][CTL_MSB] |-> !match[3])
    else $error("channel 3 compared while linked");

  pair1_hold_a: assert property (
    pair1_still_s |=> $stable(s.sel[1]))
    else $error("pair 2 changed between overflows");

  pair2_hold_a: assert property (
    pair2_still_s |=> $stable(s.sel[2]))
    else $error("pair 4 changed between overflows");

  pair0_handover_a: assert property (
    (ovf_s and s.ctl[0][CTL_MSB]) |=> s.sel[0] == $past(s.last[0]))
    else $error("pair 0 handover wrong");

  pair2_handover_a: assert property (
    (ovf_s and s.ctl[4][CTL_MSB]) |=> s.sel[2] == $past(s.last[2]))
    else $error("pair 4 handover wrong");

  set_cmp_a: assert property (
    (match[0] && s.ctl[0][CTL_ELS_HI:CTL_ELS_LO] == ELS_SET
      && !(s.ctl[0][CTL_MAX] && !s.ctl[0][CTL_TOV])) |=> chan_pin_o[0])
    else $error("set on compare failed");

  flag0_set_a: assert property (
    match[0] |=> s.ctl[0][CTL_FLAG])
    else $error("channel 0 flag not set on match");

  unbuf_miss_a: assert property (
    (en[2] && cnt_nx != act[2]) |-> !match[2])
    else $error("compare without the live value");

  max_duty0_a: assert property (
    (en[0] && s.ctl[0][CTL_MAX] && !s.ctl[0][CTL_TOV]) |=> chan_pin_o[0])
    else $error("max duty did not hold pin 0 high");

  link_enable_a: assert property (
    (s.ctl[2][CTL_MSB] && s.ctl[2][CTL_ELS_HI:CTL_ELS_LO] != ELS_OFF) |-> en[2])
    else $error("link bit did not enable channel 2");

  ovf_toggle2_a: assert property (
    (ovf_s and en[2] && s.ctl[2][CTL_TOV] && !match[2])
      |=> chan_pin_o[2] != $past(chan_pin_o[2]))
    else $error("pin 2 did not toggle at overflow");

  zero_duty_a: assert property (
    (ovf_s and match[0] && s.ctl[0][CTL_ELS_HI:CTL_ELS_LO] == ELS_CLEAR
      && !(s.ctl[0][CTL_MAX] && !s.ctl[0][CTL_TOV])) |=> !chan_pin_o[0])
    else $error("compare did not win over overflow toggle");

endmodule

`default_nettype wire

//--- verification/tb_sct_timer.sv
// Self-checking bench for the six-channel compare/PWM timer.
// Assumes sct_timer behind a classic Wishbone port on one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_sct_timer;
  import sct_pkg::*;

  logic             sys_clk  = 1'b0;
  logic             reset    = 1'b1;
  logic             cyc      = 1'b0;
  logic             stb      = 1'b0;
  logic             we       = 1'b0;
  logic [ADR_W-1:0] adr      = '0;
  logic [SEL_W-1:0] sel      = '0;
  logic [DAT_W-1:0] wdat     = '0;
  logic [DAT_W-1:0] rdat;
  logic             ack;
  logic [NCH-1:0]   pin;
  logic [NCH-1:0]   oe;
  logic [DAT_W-1:0] rd;
  int               n_fail   = 0;
  int               n_checks = 0;
  int               hi [NCH];

  always #25 sys_clk = ~sys_clk;

  sct_timer sct_timer_i (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .wb_cyc_i    (cyc),
    .wb_stb_i    (stb),
    .wb_we_i     (we),
    .wb_adr_i    (adr),
    .wb_sel_i    (sel),
    .wb_dat_i    (wdat),
    .wb_dat_o    (rdat),
    .wb_ack_o    (ack),
    .chan_pin_o  (pin),
    .chan_pin_oe (oe)
  );

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end else begin
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
    end
  endtask

  // Polls a status bit over the bus, bounded
  task automatic wait_bit(input logic [7:0] a, input int b);
    int k;
    k = 0;
    do begin
      bus(1'b0, a, 32'h0);
      k++;
    end while (rd[b] !== 1'b1 && k < 200);
    check({31'h0, rd[b]}, 32'h1);
  endtask

  // Pins repeat every 256 cycles, so any 256-cycle window gives exact duty
  task automatic measure();
    for (int c = 0; c < NCH; c++) begin
      hi[c] = 0;
    end
    repeat (256) begin
      @(posedge sys_clk);
      for (int c = 0; c < NCH; c++) begin
        hi[c] += (pin[c] === 1'b1) ? 1 : 0;
      end
    end
  endtask

  task automatic settle_and_measure();
    repeat (600) @(posedge sys_clk);
    measure();
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    check({26'h0, oe}, 32'h0);
    bus(1'b0, OFF_MOD, 32'h0);
    check(rd, 32'h0000FFFF);
    bus(1'b0, 8'hFC, 32'h0);
    check(rd, 32'h0);
    // Unbuffered setup with the counter stopped and cleared
    bus(1'b1, OFF_STAT, 32'h3);
    bus(1'b1, OFF_MOD, 32'hFF);
    bus(1'b1, OFF_CMP0, 32'h80);
    bus(1'b1, OFF_CMP0 + 8'h08, 32'h40);
    bus(1'b1, OFF_CTL0, 32'h0D);
    bus(1'b1, OFF_CTL0 + 8'h04, 32'h2C);
    bus(1'b1, OFF_CTL0 + 8'h08, 32'h0F);
    bus(1'b1, OFF_CTL0 + 8'h0C, 32'h0C);
    bus(1'b1, OFF_STAT, 32'h0);
    settle_and_measure();
    check(32'(hi[0]), 32'h80);
    check(32'(hi[1]), 32'h100);
    check(32'(hi[2]), 32'hC0);
    check(32'(hi[3]), 32'h0);
    check({26'h0, oe}, 32'h0F);
    bus(1'b0, OFF_CNT, 32'h0);
    check({16'h0, rd[15:8]}, 32'h0);
    bus(1'b0, OFF_STAT, 32'h0);
    check({31'h0, rd[STAT_OVF]}, 32'h1);
    bus(1'b0, OFF_CTL0, 32'h0);
    check({24'h0, rd[7:0]}, 32'h8D);
    // Link all three pairs; channel 0 also has the unbuffered select set
    for (int p = 0; p < NPAIR; p++) begin
      bus(1'b1, OFF_CMP0 + 8'(8 * p), 32'h40);
      bus(1'b1, OFF_CTL0 + 8'(8 * p), (p == 0) ? 32'h1D : 32'h15);
    end
    // Odd control writes must stay without effect
    bus(1'b1, OFF_CTL0 + 8'h0C, 32'h0D);
    bus(1'b1, OFF_CTL0 + 8'h14, 32'h0D);
    settle_and_measure();
    check(32'(hi[0]), 32'h40);
    check(32'(hi[2]), 32'h40);
    check(32'(hi[4]), 32'h40);
    check({31'h0, oe[1]}, 32'h0);
    check({31'h0, oe[3]}, 32'h0);
    check({31'h0, oe[5]}, 32'h0);
    check({26'h0, oe}, 32'h15);
    // Inactive halves take over after an overflow
    for (int p = 0; p < NPAIR; p++) begin
      bus(1'b1, OFF_CMP0 + 8'(8 * p + 4), 32'hC0);
    end
    settle_and_measure();
    check(32'(hi[0]), 32'hC0);
    check(32'(hi[2]), 32'hC0);
    check(32'(hi[4]), 32'hC0);
    // Even halves written last govern again
    for (int p = 0; p < NPAIR; p++) begin
      bus(1'b1, OFF_CMP0 + 8'(8 * p), 32'h20);
    end
    settle_and_measure();
    check(32'(hi[0]), 32'h20);
    check(32'(hi[2]), 32'h20);
    check(32'(hi[4]), 32'h20);
    // Unbuffered changes timed by the overflow and channel flags
    bus(1'b1, OFF_CTL0, 32'h0D);
    bus(1'b1, OFF_STAT, 32'h80);
    wait_bit(OFF_STAT, STAT_OVF);
    bus(1'b1, OFF_CMP0, 32'h90);
    settle_and_measure();
    check(32'(hi[0]), 32'h90);
    bus(1'b1, OFF_CTL0, 32'h8D);
    wait_bit(OFF_CTL0, CTL_FLAG);
    bus(1'b1, OFF_CMP0, 32'h30);
    settle_and_measure();
    check(32'(hi[0]), 32'h30);
    tally_and_finish();
  end

  // Hard stop against a hung run
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
